// *** logic/pbm_pin_mux.sv ***
`timescale 1ns/1ps
module pbm_pin_mux
  import pbm_pkg::*;
(
  input  wire logic              clk_sys_i,       // system clock, 250 mhz
  input  wire logic              reset_i,         // async reset, active high
  input  wire pbm_pkg::pbm_sel_t sel_b5_i,        // b5 function select
  input  wire pbm_pkg::pbm_sel_t sel_b6_i,        // b6 function select
  input  wire pbm_pkg::pbm_sel_t sel_b7_i,        // b7 function select
  input  wire logic              sel_b10_i,       // b10 alternate enable
  input  wire logic              sel_b11_i,       // b11 alternate enable
  input  wire logic [2:0]        sel_c_analog_i,  // c0..c2 analog enable
  input  wire logic              clk_src_sel_i,   // clock source select bit
  input  wire logic [7:0]        gpio_dir_i,      // gpio direction, 1 = out
  input  wire logic [7:0]        gpio_do_i,       // gpio output data
  input  wire logic [7:0]        pad_i,           // pad input levels
  input  wire logic              timer_a1_do_i,   // timer a ch1 out data
  input  wire logic              timer_a1_oe_i,   // timer a ch1 drives
  input  wire logic              sci_txd_i,       // serial transmit data
  input  wire logic              sci_single_i,    // single-wire mode
  input  wire logic              sci_tx_en_i,     // single-wire: transmitting
  input  wire logic              i2c_sda_oe_i,    // i2c sda pulls low
  input  wire logic              i2c_scl_oe_i,    // i2c scl pulls low
  input  wire logic              cmp_a_result_i,  // comparator a result
  input  wire logic              cmp_b_result_i,  // comparator b result
  output logic [7:0]             pad_o,           // pad output levels
  output logic [7:0]             pad_oe_n_o,      // pad enables, low drives
  output logic [7:0]             gpio_di_o,       // gpio input data
  output logic                   timer_a1_di_o,   // timer a ch1 input
  output logic                   pwm_pwm_fault_input3_o,    // pwm fault input 3
  output logic                   ext_clk_o,       // external clock input
  output logic                   sci_rxd_o,       // serial receive data
  output logic                   i2c_sda_di_o,    // i2c sda input
  output logic                   i2c_scl_di_o,    // i2c scl input
  output logic [2:0]             analog_en_o      // analog switch c0..c2
);
  import pbm_pkg::*;

  // =====================================================================
  // drive selection per pad
  // =====================================================================
  logic [PBM_NP-1:0] use_alt, alt_oe, alt_do;

  always_comb
  begin
    use_alt = '0;
    alt_oe  = '0;
    alt_do  = '0;
    // b5: timer bidirectional, fault and clock are inputs only
    use_alt[PBM_IX_B5] = (sel_b5_i != PBM_SEL_GPIO);
    if (sel_b5_i == PBM_B5_TIMER)
    begin
      alt_oe[PBM_IX_B5] = timer_a1_oe_i;
      alt_do[PBM_IX_B5] = timer_a1_do_i;
    end
    // b6: receive and clock are inputs; sda open drain
    use_alt[PBM_IX_B6] = (sel_b6_i != PBM_SEL_GPIO);
    if (sel_b6_i == PBM_B6_SDA)
    begin
      alt_oe[PBM_IX_B6] = i2c_sda_oe_i;
      alt_do[PBM_IX_B6] = 1'b0;
    end
    // b7: transmit, released while receiving in single wire
    use_alt[PBM_IX_B7] = (sel_b7_i != PBM_SEL_GPIO);
    if (sel_b7_i == PBM_B7_TXD)
    begin
      alt_oe[PBM_IX_B7] = ~sci_single_i | sci_tx_en_i;
      alt_do[PBM_IX_B7] = sci_txd_i;
    end
    else if (sel_b7_i == PBM_B7_SCL)
    begin
      alt_oe[PBM_IX_B7] = i2c_scl_oe_i;
      alt_do[PBM_IX_B7] = 1'b0;
    end
    // comparator results always drive, output only
    use_alt[PBM_IX_B10] = sel_b10_i;
    alt_oe[PBM_IX_B10]  = 1'b1;
    alt_do[PBM_IX_B10]  = cmp_a_result_i;
    use_alt[PBM_IX_B11] = sel_b11_i;
    alt_oe[PBM_IX_B11]  = 1'b1;
    alt_do[PBM_IX_B11]  = cmp_b_result_i;
    // analog on port c: digital driver off, alt_oe stays low
    use_alt[PBM_IX_C2:PBM_IX_C0] = sel_c_analog_i;
  end

  // one pad slice per covered pin
  for (genvar g = 0; g < PBM_NP; g++)
  begin : g_pad
    pbm_pad_cell u_cell (
      .clk_sys_i  (clk_sys_i),
      .reset_i    (reset_i),
      .use_alt_i  (use_alt[g]),
      .gpio_dir_i (gpio_dir_i[g]),
      .gpio_do_i  (gpio_do_i[g]),
      .alt_oe_i   (alt_oe[g]),
      .alt_do_i   (alt_do[g]),
      .pad_o      (pad_o[g]),
      .pad_oe_n_o (pad_oe_n_o[g])
    );
  end

  // =====================================================================
  // input routing to peripherals, registered
  // =====================================================================
  logic [7:0] gpio_di_r, gpio_di_nxt;
  logic       ta1_r, ta1_nxt, flt_r, flt_nxt, clk_r, clk_nxt;
  logic       rxd_r, rxd_nxt, sda_r, sda_nxt, scl_r, scl_nxt;
  logic [2:0] ana_r, ana_nxt;

  // serial and i2c idle levels are high, timer, fault and clock idle low, so unselected inputs look inactive/idle
  always_comb
  begin
    gpio_di_nxt = pad_i;
    ta1_nxt = (sel_b5_i == PBM_B5_TIMER) ? pad_i[PBM_IX_B5] : 1'b0;
    // fault active high toward pwm block
    flt_nxt = (sel_b5_i == PBM_B5_FAULT) ? pad_i[PBM_IX_B5] : 1'b0;
    // b6 clock needs both pin select and clock select bit
    clk_nxt = ((sel_b6_i == PBM_B6_EXTERNAL_CLOCK_INPUT) && clk_src_sel_i) ? pad_i[PBM_IX_B6]
            : (sel_b5_i == PBM_B5_EXTERNAL_CLOCK_INPUT) ? pad_i[PBM_IX_B5] : 1'b0;
    rxd_nxt = (sel_b6_i == PBM_B6_RXD) ? pad_i[PBM_IX_B6]
            : (sel_b7_i == PBM_B7_TXD && sci_single_i) ? pad_i[PBM_IX_B7]
            : 1'b1;
    sda_nxt = (sel_b6_i == PBM_B6_SDA) ? pad_i[PBM_IX_B6] : 1'b1;
    scl_nxt = (sel_b7_i == PBM_B7_SCL) ? pad_i[PBM_IX_B7] : 1'b1;
    // c0 switch feeds converter ch0 and comparator input 3 together
    ana_nxt = sel_c_analog_i;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gpio_di_r <= '0;
      ta1_r <= 1'b0;
      flt_r <= 1'b0;
      clk_r <= 1'b0;
      rxd_r <= 1'b1;
      sda_r <= 1'b1;
      scl_r <= 1'b1;
      ana_r <= '0;
    end
    else
    begin
      gpio_di_r <= gpio_di_nxt;
      ta1_r <= ta1_nxt;
      flt_r <= flt_nxt;
      clk_r <= clk_nxt;
      rxd_r <= rxd_nxt;
      sda_r <= sda_nxt;
      scl_r <= scl_nxt;
      ana_r <= ana_nxt;
    end
  end

  assign gpio_di_o     = gpio_di_r;
  assign timer_a1_di_o = ta1_r;
  assign pwm_pwm_fault_input3_o  = flt_r;
  assign ext_clk_o     = clk_r;
  assign sci_rxd_o     = rxd_r;
  assign i2c_sda_di_o  = sda_r;
  assign i2c_scl_di_o  = scl_r;
  assign analog_en_o   = ana_r;

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  gpio_dir_a: assert property (!$past(use_alt[PBM_IX_C1]) |->
    pad_oe_n_o[PBM_IX_C1] == !$past(gpio_dir_i[PBM_IX_C1]))
    else $error("gpio direction not followed");
  b6_clock_a: assert property (!$past(clk_src_sel_i) &&
    $past(sel_b5_i) != PBM_B5_EXTERNAL_CLOCK_INPUT |-> !ext_clk_o)
    else $error("b6 clock passed without clock select");
  fault_route_a: assert property ($past(sel_b5_i) == PBM_B5_FAULT |->
    pwm_pwm_fault_input3_o == $past(pad_i[PBM_IX_B5]))
    else $error("fault input not routed");
  analog_off_a: assert property ($past(sel_c_analog_i[0]) |->
    pad_oe_n_o[PBM_IX_C0] && analog_en_o[0])
    else $error("c0 driven while analog");
  cmp_out_a: assert property ($past(sel_b10_i) |->
    !pad_oe_n_o[PBM_IX_B10] && pad_o[PBM_IX_B10] == $past(cmp_a_result_i))
    else $error("comparator a result not driven");
  txd_drive_a: assert property ($past(sel_b7_i) == PBM_B7_TXD &&
    !$past(sci_single_i) |-> !pad_oe_n_o[PBM_IX_B7] && pad_o[PBM_IX_B7] == $past(sci_txd_i))
    else $error("transmit not driven");
  sda_route_a: assert property ($past(sel_b6_i) == PBM_B6_SDA |->
    i2c_sda_di_o == $past(pad_i[PBM_IX_B6]))
    else $error("sda input not routed");
  timer_route_a: assert property ($past(sel_b5_i) == PBM_B5_TIMER |->
    timer_a1_di_o == $past(pad_i[PBM_IX_B5]) && pad_oe_n_o[PBM_IX_B5] == !$past(timer_a1_oe_i))
    else $error("timer channel not routed");
  gpio_default_a: assert property ($past(sel_b11_i) == 1'b0 |->
    pad_o[PBM_IX_B11] == $past(gpio_do_i[PBM_IX_B11]))
    else $error("gpio default lost");
  cmp_b_out_a: assert property ($past(sel_b11_i) |->
    !pad_oe_n_o[PBM_IX_B11] && pad_o[PBM_IX_B11] == $past(cmp_b_result_i))
    else $error("comparator b result not driven");
  // single wire: the pad is only driven while the transmitter owns the line
  single_wire_a: assert property ($past(sel_b7_i) == PBM_B7_TXD &&
    $past(sci_single_i) |-> pad_oe_n_o[PBM_IX_B7] == !$past(sci_tx_en_i))
    else $error("single-wire drive not following transmit enable");
  single_rx_a: assert property ($past(sel_b7_i) == PBM_B7_TXD &&
    $past(sci_single_i) && $past(sel_b6_i) != PBM_B6_RXD |->
    sci_rxd_o == $past(pad_i[PBM_IX_B7]))
    else $error("single-wire receive not routed");
  rxd_route_a: assert property ($past(sel_b6_i) == PBM_B6_RXD |->
    sci_rxd_o == $past(pad_i[PBM_IX_B6]))
    else $error("receive input not routed");
  scl_route_a: assert property ($past(sel_b7_i) == PBM_B7_SCL |->
    i2c_scl_di_o == $past(pad_i[PBM_IX_B7]) && pad_oe_n_o[PBM_IX_B7] == !$past(i2c_scl_oe_i))
    else $error("scl not routed");
  // b6 clock has priority, so only check b5 when b6 is not a clock pin
  b5_clock_a: assert property ($past(sel_b5_i) == PBM_B5_EXTERNAL_CLOCK_INPUT &&
    $past(sel_b6_i) != PBM_B6_EXTERNAL_CLOCK_INPUT |-> ext_clk_o == $past(pad_i[PBM_IX_B5]))
    else $error("b5 clock input not routed");
  fault_no_drive_a: assert property ($past(sel_b5_i) == PBM_B5_FAULT |->
    pad_oe_n_o[PBM_IX_B5])
    else $error("fault pin driven");
  c0_analog_a: assert property (analog_en_o[0] == $past(sel_c_analog_i[0]))
    else $error("c0 analog switch not following select");
endmodule // pbm_pin_mux

// *** logic/pbm_pkg.sv ***
package pbm_pkg;
  // =====================================================================
  // function select codes, per pin (2 bits each)
  // =====================================================================
  typedef logic [1:0] pbm_sel_t;
  localparam pbm_sel_t PBM_SEL_GPIO = 2'h0;  // default after reset
  localparam pbm_sel_t PBM_SEL_ALT1 = 2'h1;
  localparam pbm_sel_t PBM_SEL_ALT2 = 2'h2;
  localparam pbm_sel_t PBM_SEL_ALT3 = 2'h3;

  // port b pin 5 alternates
  localparam pbm_sel_t PBM_B5_TIMER = PBM_SEL_ALT1;
  localparam pbm_sel_t PBM_B5_FAULT = PBM_SEL_ALT2;
  localparam pbm_sel_t PBM_B5_EXTERNAL_CLOCK_INPUT = PBM_SEL_ALT3;
  // port b pin 6 alternates
  localparam pbm_sel_t PBM_B6_RXD   = PBM_SEL_ALT1;
  localparam pbm_sel_t PBM_B6_SDA   = PBM_SEL_ALT2;
  localparam pbm_sel_t PBM_B6_EXTERNAL_CLOCK_INPUT = PBM_SEL_ALT3;
  // port b pin 7 alternates
  localparam pbm_sel_t PBM_B7_TXD   = PBM_SEL_ALT1;
  localparam pbm_sel_t PBM_B7_SCL   = PBM_SEL_ALT2;
  // pins 10, 11 and port c: one alternate each
  localparam pbm_sel_t PBM_ALT_ONLY = PBM_SEL_ALT1;

  // pin counts
  localparam int PBM_NB = 5;  // b5 b6 b7 b10 b11
  localparam int PBM_NC = 3;  // c0 c1 c2
  localparam int PBM_NP = PBM_NB + PBM_NC;
  // pad index of each covered pin in the packed vectors
  localparam int PBM_IX_B5  = 0;
  localparam int PBM_IX_B6  = 1;
  localparam int PBM_IX_B7  = 2;
  localparam int PBM_IX_B10 = 3;
  localparam int PBM_IX_B11 = 4;
  localparam int PBM_IX_C0  = 5;
  localparam int PBM_IX_C1  = 6;
  localparam int PBM_IX_C2  = 7;
endpackage

// *** logic/pbm_pad_cell.sv ***
`timescale 1ns/1ps
// =====================================================================
// one registered pad slice: selects gpio or peripheral drive
// =====================================================================
module pbm_pad_cell
  import pbm_pkg::*;
(
  input  wire logic clk_sys_i,  // system clock
  input  wire logic reset_i,    // async reset, active high
  input  wire logic use_alt_i,  // alternate function chosen
  input  wire logic gpio_dir_i, // gpio direction, 1 = output
  input  wire logic gpio_do_i,  // gpio output data
  input  wire logic alt_oe_i,   // peripheral wants to drive
  input  wire logic alt_do_i,   // peripheral output data
  output logic      pad_o,      // pad output level
  output logic      pad_oe_n_o  // pad output enable, low drives
);
  logic pad_r, pad_nxt, oe_n_r, oe_n_nxt;

  // next pad state from selected source
  always_comb
  begin
    pad_nxt  = use_alt_i ? alt_do_i : gpio_do_i;
    oe_n_nxt = use_alt_i ? ~alt_oe_i : ~gpio_dir_i;
  end

  // reset leaves pad as input, not driving
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pad_r  <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      pad_r  <= pad_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign pad_o      = pad_r;
  assign pad_oe_n_o = oe_n_r;
endmodule // pbm_pad_cell

// *** testbench/pbm_pin_mux_bench.sv ***
`timescale 1ns/1ps
module pbm_pin_mux_bench;
  import pbm_pkg::*;
  // =====================================================================
  // stimulus and observed signals
  // =====================================================================
  logic       clk_sys_i = 1'b0;
  logic       reset_i   = 1'b1;
  pbm_sel_t   s5 = PBM_SEL_GPIO, s6 = PBM_SEL_GPIO, s7 = PBM_SEL_GPIO;
  logic       s10 = 1'b0, s11 = 1'b0, csel = 1'b0;
  logic [2:0] sc = 3'h0;
  logic [7:0] dir = 8'h00, dout = 8'h00, pin = 8'hff;
  logic       t_do = 1'b0, t_oe = 1'b0, txd = 1'b1, sgl = 1'b0, txen = 1'b0;
  logic       sda_oe = 1'b0, scl_oe = 1'b0, cmpa = 1'b0, cmpb = 1'b0;
  logic [7:0] pad, oen, gdi;
  logic       tdi, flt, eclk, rxd, sdai, scli;
  logic [2:0] ana;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles     = 0;

  pbm_pin_mux dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sel_b5_i(s5), .sel_b6_i(s6),
    .sel_b7_i(s7), .sel_b10_i(s10), .sel_b11_i(s11), .sel_c_analog_i(sc),
    .clk_src_sel_i(csel), .gpio_dir_i(dir), .gpio_do_i(dout), .pad_i(pin),
    .timer_a1_do_i(t_do), .timer_a1_oe_i(t_oe), .sci_txd_i(txd), .sci_single_i(sgl),
    .sci_tx_en_i(txen), .i2c_sda_oe_i(sda_oe), .i2c_scl_oe_i(scl_oe),
    .cmp_a_result_i(cmpa), .cmp_b_result_i(cmpb), .pad_o(pad), .pad_oe_n_o(oen),
    .gpio_di_o(gdi), .timer_a1_di_o(tdi), .pwm_pwm_fault_input3_o(flt), .ext_clk_o(eclk),
    .sci_rxd_o(rxd), .i2c_sda_di_o(sdai), .i2c_scl_di_o(scli), .analog_en_o(ana));

  // =====================================================================
  // clock, hang guard and shared helpers
  // =====================================================================
  always #2 clk_sys_i = ~clk_sys_i;

  // the whole run takes well under 200 cycles, so 2000 means a hang
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic nxt();
    @(posedge clk_sys_i);
  endtask

  // outputs are registered: one edge to take the inputs, then let it settle
  task automatic look();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_vec(what, {7'h00, exp}, {7'h00, got});
  endtask

  // =====================================================================
  // scenarios
  // =====================================================================
  task automatic t_reset();
    #1;
    chk_vec("oe_n in reset", 8'hff, oen);
    chk_bit("rxd idle", 1'b1, rxd);
    nxt();
    reset_i <= 1'b0;
    dir     <= 8'hff;
    look();
    chk_vec("gpio default", 8'h00, oen);
    chk_vec("analog off", 8'h00, {5'h00, ana});
    $display("test reset done");
  endtask

  task automatic t_gpio();
    nxt();
    dir  <= 8'ha5;
    dout <= 8'hff;
    pin  <= 8'h3c;
    look();
    chk_vec("oe_n per pin", 8'h5a, oen);
    chk_vec("pad out", 8'ha5, pad & 8'ha5);
    chk_vec("gpio in", 8'h3c, gdi);
    $display("test gpio done");
  endtask

  task automatic t_b5();
    nxt();
    s5   <= PBM_B5_TIMER;
    dir  <= 8'h00;
    t_oe <= 1'b1;
    t_do <= 1'b1;
    pin  <= 8'h01;
    look();
    chk_bit("b5 timer oe_n", 1'b0, oen[0]);
    chk_bit("b5 timer out", 1'b1, pad[0]);
    chk_bit("b5 timer in", 1'b1, tdi);
    nxt();
    s5  <= PBM_B5_FAULT;
    dir <= 8'h01;
    look();
    chk_bit("b5 fault", 1'b1, flt);
    chk_bit("b5 fault oe_n", 1'b1, oen[0]);
    nxt();
    s5 <= PBM_B5_EXTERNAL_CLOCK_INPUT;  // pin stays high so a routed clock reads one, not idle zero
    look();
    chk_bit("b5 clock", 1'b1, eclk);
    chk_bit("fault idle", 1'b0, flt);
    nxt();
    s5 <= PBM_SEL_GPIO;
    $display("test b5 done");
  endtask

  task automatic t_b6();
    nxt();
    s6  <= PBM_B6_RXD;
    pin <= 8'h00;
    look();
    chk_bit("b6 rxd", 1'b0, rxd);
    nxt();
    s6     <= PBM_B6_SDA;
    sda_oe <= 1'b1;
    look();
    chk_bit("b6 sda oe_n", 1'b0, oen[1]);
    chk_bit("b6 sda out", 1'b0, pad[1]);
    chk_bit("b6 sda in", 1'b0, sdai);
    chk_bit("rxd idle", 1'b1, rxd);
    nxt();
    s6   <= PBM_B6_EXTERNAL_CLOCK_INPUT;
    pin  <= 8'h02;
    csel <= 1'b0;
    look();
    chk_bit("b6 clk blocked", 1'b0, eclk);
    nxt();
    csel <= 1'b1;
    look();
    chk_bit("b6 clk passed", 1'b1, eclk);
    nxt();
    s6     <= PBM_SEL_GPIO;
    csel   <= 1'b0;
    sda_oe <= 1'b0;
    $display("test b6 done");
  endtask

  task automatic t_b7();
    nxt();
    // gpio data is all ones, so a low pad proves the transmit path
    s7  <= PBM_B7_TXD;
    txd <= 1'b0;
    dir <= 8'h00;
    look();
    chk_bit("b7 tx oe_n", 1'b0, oen[2]);
    chk_bit("b7 tx out", 1'b0, pad[2]);
    nxt();
    sgl  <= 1'b1;
    txen <= 1'b0;
    pin  <= 8'h00;
    look();
    chk_bit("b7 single oe_n", 1'b1, oen[2]);
    chk_bit("b7 single rx", 1'b0, rxd);
    nxt();
    txen <= 1'b1;
    look();
    chk_bit("b7 single tx oe_n", 1'b0, oen[2]);
    chk_bit("b7 single tx out", 1'b0, pad[2]);
    nxt();
    s7     <= PBM_B7_SCL;
    sgl    <= 1'b0;
    txen   <= 1'b0;
    scl_oe <= 1'b1;
    look();
    chk_bit("b7 scl oe_n", 1'b0, oen[2]);
    chk_bit("b7 scl out", 1'b0, pad[2]);
    chk_bit("b7 scl in", 1'b0, scli);
    nxt();
    s7     <= PBM_SEL_GPIO;
    scl_oe <= 1'b0;
    $display("test b7 done");
  endtask

  task automatic t_cmp();
    nxt();
    s10  <= 1'b1;
    s11  <= 1'b1;
    cmpa <= 1'b1;
    cmpb <= 1'b0;
    dir  <= 8'h00;
    look();
    chk_vec("cmp oe_n", 8'h00, {6'h00, oen[4:3]});
    chk_vec("cmp out", 8'h01, {6'h00, pad[4:3]});
    nxt();
    cmpa <= 1'b0;
    cmpb <= 1'b1;
    look();
    chk_vec("cmp swap", 8'h02, {6'h00, pad[4:3]});
    $display("test comparator done");
  endtask

  task automatic t_analog();
    nxt();
    sc  <= 3'h5;
    dir <= 8'he0;
    look();
    chk_vec("analog en", 8'h05, {5'h00, ana});
    chk_vec("c oe_n", 8'h05, {5'h00, oen[7:5]});
    $display("test analog done");
  endtask

  // =====================================================================
  // verdict
  // =====================================================================
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    t_reset();
    t_gpio();
    t_b5();
    t_b6();
    t_b7();
    t_cmp();
    t_analog();
    test_done();
  end
endmodule // pbm_pin_mux_bench
